//--- spm_mux.sv
/*
 * external bus select register with ahb-lite slave and the pin routing
 * that it steers for both serial ports and six upper address pins.
 * assumes pin inputs come from pads (synchronised here); peripheral
 * outputs are on clk.
 */
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module spm_mux
   import spm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // serial port 0 and 1 pads
   input  wire logic [5:0]  sp0_pin_in,
   output spm_pins_t        sp0_pin,
   input  wire logic [5:0]  sp1_pin_in,
   output spm_pins_t        sp1_pin,
   // card controllers
   input  wire spm_pins_t   card_ctrl_first_out,
   output logic      [5:0]  card_ctrl_first_in,
   input  wire spm_pins_t   card_ctrl_second_out,
   output logic      [5:0]  card_ctrl_second_in,
   // audio ports, four signals each
   input  wire logic [7:0]  audio_port_first_out,
   output logic      [3:0]  audio_port_first_in,
   input  wire logic [7:0]  audio_port_second_out,
   output logic      [3:0]  audio_port_second_in,
   // gpio lines 0..11 and 21..26
   input  wire logic [11:0] general_io_line_out,
   input  wire logic [11:0] general_io_line_oe,
   output logic      [11:0] general_io_line_in,
   input  wire logic [5:0]  gpio_hi_out,
   input  wire logic [5:0]  gpio_hi_oe,
   output logic      [5:0]  gpio_hi_in,
   // memory interface address lines 15..20
   input  wire logic [5:0]  ext_mem_addr_out,
   input  wire logic [5:0]  addr_pin_in,
   output spm_pins_t        addr_pin,
   output spm_sel_t         sel_state
);
   // ----------------------------------------
   // reset and pad synchronisers
   // ----------------------------------------
   logic        rst_s1_ff, rst_n_ff;
   logic [17:0] pin_s1_ff, pin_s2_ff;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_ff <= 1'b0;
         rst_n_ff  <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n_ff  <= rst_s1_ff;
      end
   end
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pin_s1_ff <= 18'h00000;
         pin_s2_ff <= 18'h00000;
      end else begin
         pin_s1_ff <= {addr_pin_in, sp1_pin_in, sp0_pin_in};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   wire [5:0] sp0_in = pin_s2_ff[5:0];
   wire [5:0] sp1_in = pin_s2_ff[11:6];
   wire [5:0] ad_in  = pin_s2_ff[17:12];

   // ----------------------------------------
   // ahb-lite slave, zero wait
   // ----------------------------------------
   logic        wr_pend_ff, rd_hit_ff;
   logic [15:0] sel_ff;
   wire         acc     = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire         hit     = haddr == EXT_BUS_SEL_OFS;
   wire  [15:0] nxt_sel = (hwdata[15:0] & EXT_BUS_SEL_WMSK)
                          | (sel_ff & ~EXT_BUS_SEL_WMSK); // R7
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         wr_pend_ff <= 1'b0;
         rd_hit_ff  <= 1'b0;
         sel_ff     <= EXT_BUS_SEL_RST; // R15
      end else begin
         wr_pend_ff <= acc & hwrite & hit;
         rd_hit_ff  <= acc & ~hwrite & hit;
         if (wr_pend_ff)
            sel_ff <= nxt_sel;
      end
   end
   // unmapped reads answer zero; writes there are dropped
   assign hrdata    = rd_hit_ff ? {16'h0000, sel_ff} : 32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ----------------------------------------
   // pin routing
   // ----------------------------------------
   // software must reset peripherals after a change; no glitch guard here
   wire [1:0] sp1_route = sel_ff[SP1_LSB +: 2];
   wire [1:0] sp0_route = sel_ff[SP0_LSB +: 2];
   wire [5:0] a_sel     = sel_ff[ADDR_SEL_W-1:0];
   assign sel_state = '{sp1: sp1_route, sp0: sp0_route, addr: a_sel};

   // one port: card pins, or audio(4 low) + gpio pair high, or six gpio
   function automatic spm_pins_t port_out(input logic [1:0] r,
                                          input spm_pins_t card,
                                          input logic [7:0] aud,
                                          input logic [5:0] go,
                                          input logic [5:0] ge);
      spm_pins_t p;
      p = '{o: 6'h00, oe: 6'h00};
      unique case (r)
         ROUTE_CARD:  p = card;
         ROUTE_AUDIO: p = '{o: {go[5:4], aud[3:0]}, oe: {ge[5:4], aud[7:4]}};
         ROUTE_GPIO:  p = '{o: go, oe: ge};
         default:     p = '{o: 6'h00, oe: 6'h00};
      endcase
      return p;
   endfunction

   assign sp1_pin = port_out(sp1_route, card_ctrl_second_out, audio_port_second_out,
                             general_io_line_out[11:6], general_io_line_oe[11:6]); // R1 R2 R3
   assign sp0_pin = port_out(sp0_route, card_ctrl_first_out, audio_port_first_out,
                             general_io_line_out[5:0], general_io_line_oe[5:0]); // R4 R5 R6

   assign card_ctrl_second_in  = (sp1_route == ROUTE_CARD) ? sp1_in : 6'h00; // R1
   assign card_ctrl_first_in   = (sp0_route == ROUTE_CARD) ? sp0_in : 6'h00; // R4
   assign audio_port_second_in = (sp1_route == ROUTE_AUDIO) ? sp1_in[3:0] : 4'h0; // R2
   assign audio_port_first_in  = (sp0_route == ROUTE_AUDIO) ? sp0_in[3:0] : 4'h0; // R5
   assign general_io_line_in[11:10] = (sp1_route == ROUTE_AUDIO || sp1_route == ROUTE_GPIO)
                                      ? sp1_in[5:4] : 2'h0; // R2 R3
   assign general_io_line_in[9:6]   = (sp1_route == ROUTE_GPIO) ? sp1_in[3:0] : 4'h0; // R3
   assign general_io_line_in[5:4]   = (sp0_route == ROUTE_AUDIO || sp0_route == ROUTE_GPIO)
                                      ? sp0_in[5:4] : 2'h0; // R5 R6
   assign general_io_line_in[3:0]   = (sp0_route == ROUTE_GPIO) ? sp0_in[3:0] : 4'h0; // R6

   // address pins: memory interface drives always when selected
   assign addr_pin.o  = (a_sel & gpio_hi_out) | (~a_sel & ext_mem_addr_out); // R8 R9 R10 R11 R12 R13
   assign addr_pin.oe = (a_sel & gpio_hi_oe) | ~a_sel; // R8 R9 R10 R11 R12 R13
   assign gpio_hi_in  = a_sel & ad_in; // R8 R9 R10 R11 R12 R13

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_sp1_card_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R1
      sp1_route == ROUTE_CARD |-> sp1_pin == card_ctrl_second_out)
      else $error("sp1 card route wrong");
   a_sp1_audio_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R2
      sp1_route == ROUTE_AUDIO |-> sp1_pin.o[3:0] == audio_port_second_out[3:0]
      && sp1_pin.o[5:4] == general_io_line_out[11:10])
      else $error("sp1 audio route wrong");
   a_sp1_gpio_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R3
      sp1_route == ROUTE_GPIO |-> sp1_pin.o == general_io_line_out[11:6])
      else $error("sp1 gpio route wrong");
   a_sp0_card_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R4
      sp0_route == ROUTE_CARD |-> sp0_pin == card_ctrl_first_out)
      else $error("sp0 card route wrong");
   a_sp0_audio_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R5
      sp0_route == ROUTE_AUDIO |-> sp0_pin.oe[3:0] == audio_port_first_out[7:4]
      && sp0_pin.o[3:0] == audio_port_first_out[3:0]
      && sp0_pin.o[5:4] == general_io_line_out[5:4])
      else $error("sp0 audio route wrong");
   a_sp0_gpio_route: assert property (@(posedge clk) disable iff (!rst_n_ff) // R6
      sp0_route == ROUTE_GPIO |-> sp0_pin.oe == general_io_line_oe[5:0]
      && sp0_pin.o == general_io_line_out[5:0])
      else $error("sp0 gpio route wrong");
   a_reserved_bits_zero: assert property (@(posedge clk) disable iff (!rst_n_ff) // R7
      wr_pend_ff |=> sel_ff[7:6] == 2'h0 && sel_ff[15:12] == 4'h0)
      else $error("reserved bits changed");
   a_write_lands: assert property (@(posedge clk) disable iff (!rst_n_ff) // R8
      wr_pend_ff |=> sel_ff[5:0] == $past(hwdata[5:0]))
      else $error("address select write lost");
   a_addr_mem_drive: assert property (@(posedge clk) disable iff (!rst_n_ff) // R13
      !a_sel[0] |-> addr_pin.oe[0] && addr_pin.o[0] == ext_mem_addr_out[0])
      else $error("addr 15 not memory driven");
   a_reset_clear: assert property (@(posedge clk) // R15
      $rose(rst_n_ff) |-> sel_ff == EXT_BUS_SEL_RST)
      else $error("select not clear after reset");
   c_write_sel: cover property (@(posedge clk) disable iff (!rst_n_ff) wr_pend_ff);
   c_read_sel: cover property (@(posedge clk) disable iff (!rst_n_ff) rd_hit_ff);
   c_sp1_audio: cover property (@(posedge clk) disable iff (!rst_n_ff)
      sp1_route == ROUTE_AUDIO);
   c_addr_gpio: cover property (@(posedge clk) disable iff (!rst_n_ff) a_sel == 6'h3F);
endmodule

//--- spm_pkg.sv
/*
 * package for the serial port / address pin multiplexer: register map,
 * field positions, reset values, route codes and carrier structs.
 * assumes an ahb-lite register bus with 32-bit data and one slave.
 */
// Behaviour
// [R1] sp1 code 00: card ctrl second on pins
// [R2] sp1 code 01: audio second plus gpio 11:10
// [R3] sp1 code 10: gpio 11:6; 11 reserved
// [R4] sp0 code 00: card ctrl first on pins
// [R5] sp0 code 01: audio first plus gpio 5:4
// [R6] sp0 code 10: gpio 5:0; 11 reserved
// [R7] bits 7:6 read-only, writes ignored
// [R8] bit 5: addr 20 or gpio 26
// [R9] bit 4: addr 19 or gpio 25
// [R10] bit 3: addr 18 or gpio 24
// [R11] bit 2: addr 17 or gpio 23
// [R12] bit 1: addr 16 or gpio 22
// [R13] bit 0: addr 15 or gpio 21
// [R14] software resets affected peripherals after change
// [R15] all selection fields reset to zero
package spm_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] EXT_BUS_SEL_OFS  = 12'h000;
   localparam logic [15:0] EXT_BUS_SEL_RST  = 16'h0000;
   localparam logic [15:0] EXT_BUS_SEL_WMSK = 16'h0F3F;
   localparam int          SP1_LSB          = 10;
   localparam int          SP0_LSB          = 8;
   localparam int          ADDR_SEL_W       = 6;

   // ----------------------------------------
   // route codes
   // ----------------------------------------
   localparam logic [1:0] ROUTE_CARD  = 2'h0;
   localparam logic [1:0] ROUTE_AUDIO = 2'h1;
   localparam logic [1:0] ROUTE_GPIO  = 2'h2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [5:0] o;
      logic [5:0] oe;
   } spm_pins_t;

   typedef struct packed {
      logic [1:0] sp1;
      logic [1:0] sp0;
      logic [5:0] addr;
   } spm_sel_t;
endpackage

//--- spm_far_model.sv
/*
 * far-side model: card, audio, gpio and memory outputs around the pin mux.
 * assumes clk is the block clock and sel is the mux's sel_state.
 */
`timescale 1ns/1ns
module spm_far_model
   import spm_pkg::*;
(
   input  wire logic      clk,
   input  wire spm_sel_t  sel,
   output spm_pins_t      card0,
   output spm_pins_t      card1,
   output logic [7:0]     aud0,
   output logic [7:0]     aud1,
   output logic [11:0]    gpo,
   output logic [11:0]    gpe,
   output logic [5:0]     hio,
   output logic [5:0]     hie,
   output logic [5:0]     mem
);
   logic [11:0] c_ff    = 12'h000;
   spm_sel_t    last_ff = '0;
   // outputs except aud1 and hie move every cycle so a stale route cannot pass for a live one
   always @(posedge clk) begin
      last_ff <= sel;
      c_ff    <= (sel != last_ff) ? 12'h000 : c_ff + 12'h001;
   end
   assign card0 = c_ff;
   assign card1 = ~c_ff;
   assign aud0  = c_ff[7:0];
   assign aud1  = c_ff[11:4];
   assign gpo   = c_ff ^ 12'hA5C;
   assign gpe   = {c_ff[5:0], c_ff[11:6]};
   assign hio   = c_ff[5:0];
   assign hie   = c_ff[11:6];
   assign mem   = ~c_ff[5:0];
endmodule

//--- test_serial_port_addr_pin_mux.sv
/*
 * self-checking bench for spm_mux: ahb-lite tasks, one task per scenario.
 * assumes one slave, its hreadyout being the bus hready.
 */
`timescale 1ns/1ns
module test_serial_port_addr_pin_mux import spm_pkg::*;;
   logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp;
   logic [5:0]  cf_in, ho, he, mo;
   logic [3:0]  as_in;
   logic [7:0]  a0, a1;
   logic [11:0] go, ge;
   logic [5:0]  cs_in, hi_in;
   logic [3:0]  af_in;
   logic [11:0] gi_in;
   spm_pins_t   sp0, sp1, ap, c0, c1;
   spm_sel_t    sel;
   int          bad_count = 0, total_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   assign hready = hreadyout;
   spm_mux dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sp0_pin_in(6'h2D), .sp0_pin(sp0),
      .sp1_pin_in(6'h13), .sp1_pin(sp1), .card_ctrl_first_out(c0), .card_ctrl_first_in(cf_in),
      .card_ctrl_second_out(c1), .card_ctrl_second_in(cs_in), .audio_port_first_out(a0),
      .audio_port_first_in(af_in), .audio_port_second_out(a1), .audio_port_second_in(as_in),
      .general_io_line_out(go), .general_io_line_oe(ge), .general_io_line_in(gi_in),
      .gpio_hi_out(ho), .gpio_hi_oe(he), .gpio_hi_in(hi_in), .ext_mem_addr_out(mo),
      .addr_pin_in(6'h3A), .addr_pin(ap), .sel_state(sel));
   spm_far_model far (.clk(clk), .sel(sel), .card0(c0), .card1(c1), .aud0(a0), .aud1(a1),
      .gpo(go), .gpe(ge), .hio(ho), .hie(he), .mem(mo));
   // ---------------------------
   // bus and compare tasks
   // ---------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // negedge sampling keeps reads clear of the edge race
   task automatic phase();
      logic ok;
      ok = 1'b0;
      while (!ok) begin
         @(negedge clk);
         ok = (hreadyout === 1'b1);
         rd = hrdata;
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w; hsize <= HSIZE_WORD;
      phase();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      phase();
   endtask
   function automatic spm_pins_t exp_sp(logic [1:0] m, spm_pins_t cd, logic [7:0] au,
                                        logic [5:0] o6, logic [5:0] e6);
      case (m)
         ROUTE_CARD:  return cd;
         ROUTE_AUDIO: return {o6[5:4], au[3:0], e6[5:4], au[7:4]};
         ROUTE_GPIO:  return {o6, e6};
         default:     return '0;
      endcase
   endfunction
   // reserved route: only the released enables are defined
   function automatic logic [11:0] mk(logic [1:0] m);
      return (m == 2'h3) ? 12'h03F : 12'hFFF;
   endfunction
   task automatic look(input logic [9:0] v);
      spm_pins_t ea;
      @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         ea.o[i]  = v[i] ? ho[i] : mo[i];
         ea.oe[i] = v[i] ? he[i] : 1'b1;
      end
      chk("sel_state", v, sel);
      chk("sp0_pin", exp_sp(v[7:6], c0, a0, go[5:0], ge[5:0]) & mk(v[7:6]), sp0 & mk(v[7:6]));
      chk("sp1_pin", exp_sp(v[9:8], c1, a1, go[11:6], ge[11:6]) & mk(v[9:8]), sp1 & mk(v[9:8]));
      chk("addr_pin", ea, ap);
      chk("card1_in", (v[9:8] == ROUTE_CARD) ? 6'h13 : 6'h00, cs_in);
      chk("audio0_in", (v[7:6] == ROUTE_AUDIO) ? 4'hD : 4'h0, af_in);
      chk("gpio_in", {(v[9:8] == ROUTE_AUDIO || v[9:8] == ROUTE_GPIO) ? 2'h1 : 2'h0,
                      (v[9:8] == ROUTE_GPIO) ? 4'h3 : 4'h0,
                      (v[7:6] == ROUTE_AUDIO || v[7:6] == ROUTE_GPIO) ? 2'h2 : 2'h0,
                      (v[7:6] == ROUTE_GPIO) ? 4'hD : 4'h0}, gi_in);
      chk("gpio_hi_in", v[5:0] & 6'h3A, hi_in);
      @(posedge clk);
   endtask
   // ---------------------------
   // scenarios
   // ---------------------------
   task automatic t_reset();
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1'b0, EXT_BUS_SEL_OFS, 32'h0);
      chk("reg_reset", 32'h0, rd);
      look(10'h000);
      $display("t_reset done");
   endtask
   task automatic t_routes();
      logic [15:0] r;
      for (int m = 0; m < 4; m++) begin
         r = {4'h0, m[1:0], 2'(3 - m), 8'h00};
         bus(1'b1, EXT_BUS_SEL_OFS, {16'h0000, r});
         repeat (3) @(posedge clk);
         look({r[11:8], r[5:0]});
         chk("card0_in", (r[9:8] == ROUTE_CARD) ? 6'h2D : 6'h00, cf_in);
         chk("audio1_in", (r[11:10] == ROUTE_AUDIO) ? 4'h3 : 4'h0, as_in);
      end
      $display("t_routes done");
   endtask
   task automatic t_addr();
      bus(1'b1, EXT_BUS_SEL_OFS, 32'h0000_062A);
      bus(1'b1, EXT_BUS_SEL_OFS, 32'h0000_0915);
      look(10'h255);
      bus(1'b0, EXT_BUS_SEL_OFS, 32'h0);
      chk("reg_read", 32'h0000_0915, rd);
      $display("t_addr done");
   endtask
   task automatic t_reserved();
      bus(1'b1, EXT_BUS_SEL_OFS, 32'hFFFF_FFFF);
      bus(1'b0, EXT_BUS_SEL_OFS, 32'h0);
      chk("reg_masked", 32'h0000_0F3F, rd);
      chk("hresp", 32'h0, hresp);
      look(10'h3FF);
      bus(1'b1, 12'h004, 32'h0);
      bus(1'b0, 12'h004, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, EXT_BUS_SEL_OFS, 32'h0);
      chk("reg_kept", 32'h0000_0F3F, rd);
      $display("t_reserved done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      t_reset();
      t_routes();
      t_addr();
      t_reserved();
      t_reset();
      stop_test();
   end
endmodule
